// file: hdl/psp_pkg.sv
// Overview of operation
// - Input-full flag shows unread host byte
// - Overrun flag sticks until software clears
// - Select bit switches data port to slave
// - Low three bits set pin directions
// - Control pins become read, write, select
// - CPU writes output latch, reads input latch in slave mode and the pins outside it
// - Data direction register ignored in slave mode
// - Write starts with select and write low
// - Write end sets flags after phases
// - In slave mode only CPU data read clears input-full
// - Write on unread byte sets overrun
// - Read start clears output-full at once
// - Read end sets interrupt flag after phases
// - CPU data write sets output-full again
// - Outside slave mode full flags held clear
// - Completion latches interrupt flag, enable masks
// - Control/status resets to 0000 -111
// - Read drives output latch, write captures pins
// - Analog control pins read back zero
package psp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IDX_W      = 8;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned CPIN_W     = 3;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DATA_PORT = 8'h08;
  localparam logic [IDX_W-1:0] IDX_DATA_DIR  = 8'h88;
  localparam logic [IDX_W-1:0] IDX_CPIN_PORT = 8'h09;
  localparam logic [IDX_W-1:0] IDX_CSR       = 8'h89;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAG  = 8'h0c;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN    = 8'h8c;
  localparam logic [IDX_W-1:0] IDX_ACFG      = 8'h9f;

  // Control/status field positions
  localparam int unsigned CSR_IBF_BIT  = 7;
  localparam int unsigned CSR_OBF_BIT  = 6;
  localparam int unsigned CSR_INPUT_OVERRUN_FLAG_BIT = 5;
  localparam int unsigned CSR_MODE_BIT = 4;
  localparam int unsigned IRQ_BIT      = 7;

  // Control pin order from the lowest pin
  localparam int unsigned PIN_RD = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_CS = 2;

  // Reset values
  localparam logic [BYTE_W-1:0] CSR_RESET     = 8'h07;
  localparam logic [CPIN_W-1:0] CPIN_DIR_RST  = 3'h7;
  localparam logic [BYTE_W-1:0] DATA_DIR_RST  = 8'hff;
  localparam logic [CPIN_W-1:0] ACFG_RESET    = 3'h0;
  localparam logic [CPIN_W-1:0] ACFG_DIGITAL  = 3'h7;

  // Phase sequencer: four clocks per instruction cycle
  localparam logic [1:0] PH_TWO  = 2'h1;
  localparam logic [1:0] PH_FOUR = 2'h3;

  // Host transfer sequencer, one-hot
  typedef enum logic [4:0] {
    PSP_IDLE    = 5'b00001,
    PSP_WR_ACT  = 5'b00010,
    PSP_RD_ACT  = 5'b00100,
    PSP_WAIT_Q2 = 5'b01000,
    PSP_WAIT_Q4 = 5'b10000
  } psp_fsm_t;

  // Whole state of the port
  typedef struct packed {
    psp_fsm_t            fsm;
    logic                wr_kind;
    logic [BYTE_W-1:0]   in_latch;
    logic [BYTE_W-1:0]   out_latch;
    logic [BYTE_W-1:0]   data_dir;
    logic [CPIN_W-1:0]   cpin_latch;
    logic [CPIN_W-1:0]   cpin_dir;
    logic                mode;
    logic                input_full_flag;
    logic                output_full_flag;
    logic                input_overrun_flag;
    logic [CPIN_W-1:0]   acfg;
    logic                irq_flag;
    logic                irq_en;
    logic                irq;
    logic                pready;
    logic                pslverr;
    logic [DATA_W-1:0]   prdata;
    logic [BYTE_W-1:0]   pd_o;
    logic [BYTE_W-1:0]   pd_oe;
    logic [CPIN_W-1:0]   cp_o;
    logic [CPIN_W-1:0]   cp_oe;
  } psp_state_t;

endpackage

// file: hdl/psp_phase_gen.sv
`timescale 1ns/10ps
module psp_phase_gen
  import psp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      phase_two,
  output logic      phase_four
);

  logic [1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running quarter counter and registered phase pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= 2'h0;
      phase_two  <= 1'b0;
      phase_four <= 1'b0;
    end else begin
      cnt_q      <= cnt_q + 2'h1;
      phase_two  <= (cnt_q == PH_TWO);
      phase_four <= (cnt_q == PH_FOUR);
    end
  end

endmodule // psp_phase_gen

// file: hdl/psp_slave_port.sv
`timescale 1ns/10ps
module psp_slave_port
  import psp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [BYTE_W-1:0] pd_i,
  output logic      [BYTE_W-1:0] pd_o,
  output logic      [BYTE_W-1:0] pd_oe,
  input  wire logic [CPIN_W-1:0] cp_i,
  output logic      [CPIN_W-1:0] cp_o,
  output logic      [CPIN_W-1:0] cp_oe,
  output logic                   slave_port_irq
);

  psp_state_t s_q;
  psp_state_t s_d;
  logic       phase_two;
  logic       phase_four;

  ////////////////////////////////////////////////////////////////////////////////
  // Phase pulses for completion timing
  psp_phase_gen u_phase (
    .pclk       (pclk),
    .presetn    (presetn),
    .phase_two  (phase_two),
    .phase_four (phase_four)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode for the error response; the read mux uses reg_hit
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    reg_mapped = (a[1:0] == 2'h0) &&
                 (idx == IDX_DATA_PORT || idx == IDX_DATA_DIR || idx == IDX_CPIN_PORT ||
                  idx == IDX_CSR || idx == IDX_IRQ_FLAG || idx == IDX_IRQ_EN ||
                  idx == IDX_ACFG);
  endfunction

  // Register hit test for one index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
    reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
  endfunction

  // Control pin readback; analog pins read zero
  function automatic logic [CPIN_W-1:0] cpin_read(input psp_state_t s,
                                                  input logic [CPIN_W-1:0] pins);
    logic [CPIN_W-1:0] r;
    r = '0;
    for (int i = 0; i < CPIN_W; i++) begin
      if (s.cpin_dir[i]) begin
        r[i] = (s.acfg == ACFG_DIGITAL) ? pins[i] : 1'b0;
      end else begin
        r[i] = s.cpin_latch[i];
      end
    end
    cpin_read = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe decode and bus phase terms
  logic cs_low;
  logic wr_low;
  logic rd_low;
  logic wr_start;
  logic rd_start;
  logic wr_release;
  logic rd_release;
  logic ev_done;
  logic apb_setup;
  logic apb_done;
  logic cpu_wr_data;
  logic cpu_rd_data;
  logic cpu_wr_csr;
  logic cpu_wr_irqf;

  // Control pins act as strobes only in slave mode
  assign cs_low      = s_q.mode && !cp_i[PIN_CS];
  assign wr_low      = !cp_i[PIN_WR];
  assign rd_low      = !cp_i[PIN_RD];
  assign wr_start    = (s_q.fsm == PSP_IDLE) && cs_low && wr_low;
  assign rd_start    = (s_q.fsm == PSP_IDLE) && cs_low && rd_low && !wr_low;
  assign wr_release  = (s_q.fsm == PSP_WR_ACT) && !(cs_low && wr_low);
  assign rd_release  = (s_q.fsm == PSP_RD_ACT) && !(cs_low && rd_low);
  assign ev_done     = (s_q.fsm == PSP_WAIT_Q4) && phase_four;
  assign apb_setup   = psel && !penable;
  assign apb_done    = psel && penable && s_q.pready;
  assign cpu_wr_data = apb_done && pwrite && pstrb[0] && reg_hit(paddr, IDX_DATA_PORT);
  assign cpu_rd_data = apb_done && !pwrite && reg_hit(paddr, IDX_DATA_PORT);
  assign cpu_wr_csr  = apb_done && pwrite && pstrb[0] && reg_hit(paddr, IDX_CSR);
  assign cpu_wr_irqf = apb_done && pwrite && pstrb[0] && reg_hit(paddr, IDX_IRQ_FLAG);

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d = s_q;

    // Host transfer sequencer
    case (s_q.fsm)
      PSP_IDLE: begin
        if (wr_start) begin
          s_d.fsm      = PSP_WR_ACT;
          s_d.in_latch = pd_i;
        end else if (rd_start) begin
          s_d.fsm = PSP_RD_ACT;
        end
      end
      PSP_WR_ACT: begin
        if (wr_release) begin
          s_d.fsm     = PSP_WAIT_Q2;
          s_d.wr_kind = 1'b1;
        end else begin
          s_d.in_latch = pd_i;
        end
      end
      PSP_RD_ACT: begin
        if (rd_release) begin
          s_d.fsm     = PSP_WAIT_Q2;
          s_d.wr_kind = 1'b0;
        end
      end
      PSP_WAIT_Q2: begin
        if (phase_two) begin
          s_d.fsm = PSP_WAIT_Q4;
        end
      end
      PSP_WAIT_Q4: begin
        if (phase_four) begin
          s_d.fsm = PSP_IDLE;
        end
      end
      default: begin
        s_d.fsm = PSP_IDLE;
      end
    endcase
    if (!s_q.mode) begin
      s_d.fsm = PSP_IDLE;
    end

    // Software register writes
    if (cpu_wr_data) begin
      s_d.out_latch = pwdata[BYTE_W-1:0];
    end
    if (apb_done && pwrite && pstrb[0] && reg_hit(paddr, IDX_DATA_DIR)) begin
      s_d.data_dir = pwdata[BYTE_W-1:0];
    end
    if (apb_done && pwrite && pstrb[0] && reg_hit(paddr, IDX_CPIN_PORT)) begin
      s_d.cpin_latch = pwdata[CPIN_W-1:0];
    end
    if (cpu_wr_csr) begin
      s_d.mode     = pwdata[CSR_MODE_BIT];
      s_d.cpin_dir = pwdata[CPIN_W-1:0];
      s_d.input_overrun_flag     = pwdata[CSR_INPUT_OVERRUN_FLAG_BIT];
    end
    if (apb_done && pwrite && pstrb[0] && reg_hit(paddr, IDX_ACFG)) begin
      s_d.acfg = pwdata[CPIN_W-1:0];
    end
    if (apb_done && pwrite && pstrb[0] && reg_hit(paddr, IDX_IRQ_EN)) begin
      s_d.irq_en = pwdata[IRQ_BIT];
    end
    if (cpu_wr_irqf) begin
      s_d.irq_flag = pwdata[IRQ_BIT];
    end

    // Status flags; hardware set wins over software clear
    if (s_q.mode) begin
      if (cpu_rd_data) begin
        s_d.input_full_flag = 1'b0;
      end
      if (ev_done && s_q.wr_kind) begin
        s_d.input_full_flag = 1'b1;
      end
      if (rd_start) begin
        s_d.output_full_flag = 1'b0;
      end
      if (cpu_wr_data) begin
        s_d.output_full_flag = 1'b1;
      end
    end else begin
      s_d.input_full_flag = 1'b0;
      s_d.output_full_flag = 1'b0;
    end
    if (wr_start && s_q.input_full_flag) begin
      s_d.input_overrun_flag = 1'b1;
    end
    if (ev_done) begin
      s_d.irq_flag = 1'b1;
    end
    s_d.irq = s_q.irq_flag && s_q.irq_en;

    // Bus response, answered in the access cycle after setup
    s_d.pready  = apb_setup;
    s_d.pslverr = apb_setup && !reg_mapped(paddr);
    s_d.prdata  = '0;
    if (apb_setup && !pwrite) begin
      if (reg_hit(paddr, IDX_DATA_PORT)) begin
        s_d.prdata[BYTE_W-1:0] = s_q.mode ? s_q.in_latch : pd_i;
      end else if (reg_hit(paddr, IDX_DATA_DIR)) begin
        s_d.prdata[BYTE_W-1:0] = s_q.data_dir;
      end else if (reg_hit(paddr, IDX_CPIN_PORT)) begin
        s_d.prdata[CPIN_W-1:0] = cpin_read(s_q, cp_i);
      end else if (reg_hit(paddr, IDX_CSR)) begin
        s_d.prdata[BYTE_W-1:0] = {s_q.input_full_flag, s_q.output_full_flag, s_q.input_overrun_flag, s_q.mode,
                                  1'b0, s_q.cpin_dir};
      end else if (reg_hit(paddr, IDX_IRQ_FLAG)) begin
        s_d.prdata[IRQ_BIT] = s_q.irq_flag;
      end else if (reg_hit(paddr, IDX_IRQ_EN)) begin
        s_d.prdata[IRQ_BIT] = s_q.irq_en;
      end else if (reg_hit(paddr, IDX_ACFG)) begin
        s_d.prdata[CPIN_W-1:0] = s_q.acfg;
      end
    end

    // Pin drivers; direction register ignored in slave mode
    s_d.pd_o = s_q.out_latch;
    if (s_q.mode) begin
      s_d.pd_oe = (cs_low && rd_low) ? {BYTE_W{1'b1}} : {BYTE_W{1'b0}};
    end else begin
      s_d.pd_oe = ~s_q.data_dir;
    end
    s_d.cp_o  = s_q.cpin_latch;
    s_d.cp_oe = ~s_q.cpin_dir;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q            <= '0;
      s_q.fsm        <= PSP_IDLE;
      s_q.cpin_dir   <= CPIN_DIR_RST;
      s_q.data_dir   <= DATA_DIR_RST;
      s_q.acfg       <= ACFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign prdata         = s_q.prdata;
  assign pready         = s_q.pready;
  assign pslverr        = s_q.pslverr;
  assign pd_o           = s_q.pd_o;
  assign pd_oe          = s_q.pd_oe;
  assign cp_o           = s_q.cp_o;
  assign cp_oe          = s_q.cp_oe;
  assign slave_port_irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence wr_end_s;
    wr_release && s_q.mode && !cpu_wr_csr;
  endsequence

  sequence rd_end_s;
    rd_release && s_q.mode && !cpu_wr_csr;
  endsequence

  a_csr_reset_val: assert property ($rose(presetn) |->
    (s_q.cpin_dir == CPIN_DIR_RST && !s_q.mode && !s_q.input_overrun_flag && !s_q.input_full_flag && !s_q.output_full_flag))
    else $error("control/status not at reset value");

  a_wr_done_flags: assert property (wr_end_s ##1 (s_q.mode && !cpu_wr_csr) [*7] |->
    ##[0:1] (s_q.input_full_flag || $past(s_q.input_full_flag)))
    else $error("write completion did not set input-full");

  a_wr_irq_set: assert property (wr_end_s |=> ##[1:8] s_q.irq_flag || !s_q.mode)
    else $error("write completion did not set interrupt flag");

  a_rd_irq_set: assert property (rd_end_s |=> ##[1:8] s_q.irq_flag || !s_q.mode)
    else $error("read completion did not set interrupt flag");

  a_overrun_set: assert property (wr_start && s_q.input_full_flag |=> s_q.input_overrun_flag)
    else $error("overrun not flagged");

  a_overrun_hold: assert property (s_q.input_overrun_flag && !cpu_wr_csr |=> s_q.input_overrun_flag)
    else $error("overrun flag lost without software clear");

  a_obf_rd_clear: assert property (rd_start && !cpu_wr_data |=> !s_q.output_full_flag)
    else $error("output-full not cleared at read start");

  a_obf_cpu_set: assert property (s_q.mode && cpu_wr_data |=> s_q.output_full_flag)
    else $error("output-full not set by data write");

  a_ibf_hold: assert property (s_q.input_full_flag && s_q.mode && !cpu_rd_data |=> s_q.input_full_flag)
    else $error("input-full cleared without data read");

  a_flags_nomode: assert property (!s_q.mode ##1 !s_q.mode |-> !s_q.input_full_flag && !s_q.output_full_flag)
    else $error("full flags set outside slave mode");

  a_data_drive: assert property (cs_low && rd_low |=>
    (pd_oe == {BYTE_W{1'b1}} && pd_o == $past(s_q.out_latch)))
    else $error("selected read not driving output latch");

  a_no_drive: assert property (s_q.mode && !(cs_low && rd_low) |=> pd_oe == '0)
    else $error("data pins driven outside selected read");

  a_wr_capture: assert property ((s_q.fsm == PSP_WR_ACT) && !wr_release && s_q.mode |=>
    s_q.in_latch == $past(pd_i))
    else $error("write did not capture data pins");

  a_analog_zero: assert property (apb_setup && !pwrite && reg_hit(paddr, IDX_CPIN_PORT) &&
    (s_q.acfg != ACFG_DIGITAL) |=> (s_q.prdata[CPIN_W-1:0] & $past(s_q.cpin_dir)) == '0)
    else $error("analog control pin read nonzero");

  a_irq_output: assert property (##1 slave_port_irq == $past(s_q.irq_flag && s_q.irq_en))
    else $error("interrupt output not masked flag");

  a_apb_answer: assert property (apb_setup |=> pready ##1 !pready || apb_setup)
    else $error("bus answer not one access cycle");

  a_slverr_map: assert property (apb_setup && !reg_mapped(paddr) |=> pready && pslverr)
    else $error("unmapped access not refused");

  a_irq_hold: assert property (s_q.irq_flag && !cpu_wr_irqf |=> s_q.irq_flag)
    else $error("interrupt flag lost without software clear");

  a_ibf_at_phase: assert property ($rose(s_q.input_full_flag) |-> $past(phase_four && s_q.wr_kind))
    else $error("input-full set off the phase-four pulse");

  a_irq_at_phase: assert property ($rose(s_q.irq_flag) |->
    $past(phase_four) || $past(cpu_wr_irqf))
    else $error("interrupt flag set off the phase-four pulse");

  a_ibf_rd_clear: assert property (s_q.mode && cpu_rd_data && !ev_done |=> !s_q.input_full_flag)
    else $error("input-full not cleared by data read");

  a_dir_follow: assert property (!s_q.mode |=> pd_oe == ~$past(s_q.data_dir))
    else $error("data pins ignore direction outside slave mode");

endmodule // psp_slave_port

// file: tb/psp_host_model.sv
`timescale 1ns/10ps
module psp_host_model
  import psp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic [BYTE_W-1:0] pd,
  output logic      [CPIN_W-1:0] strobe,
  output logic      [BYTE_W-1:0] host_d
);
  // Bus idles with all strobes high and zero on the host data lines
  initial begin
    strobe = 3'h7;
    host_d = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host write: select and write low with data, then release both
  task automatic host_write(input logic [BYTE_W-1:0] b, input int hold);
    @(posedge pclk);
    strobe <= 3'h1;
    host_d <= b;
    repeat (hold) @(posedge pclk);
    strobe <= 3'h7;
    @(posedge pclk);
    host_d <= ~b; // Released bus shows no stale byte
    repeat (12) @(posedge pclk);
  endtask

  // Host read: select and read low, sample the bus late, then release
  task automatic host_read(output logic [BYTE_W-1:0] b, input int hold);
    @(posedge pclk);
    strobe <= 3'h2;
    repeat (hold) @(posedge pclk);
    b = pd;
    strobe <= 3'h7;
    repeat (12) @(posedge pclk);
  endtask
endmodule // psp_host_model

// file: tb/psp_slave_port_tb.sv
`timescale 1ns/10ps
module psp_slave_port_tb
  import psp_pkg::*;
;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [3:0]        pstrb;
  logic              pready;
  logic              pslverr;
  logic [BYTE_W-1:0] pd_i;
  logic [BYTE_W-1:0] pd_o;
  logic [BYTE_W-1:0] pd_oe;
  logic [BYTE_W-1:0] host_d;
  logic [CPIN_W-1:0] cp_i;
  logic [CPIN_W-1:0] cp_o;
  logic [CPIN_W-1:0] cp_oe;
  logic [CPIN_W-1:0] strobe;
  logic              slave_port_irq;
  logic [DATA_W-1:0] rd;
  logic              err;
  logic [BYTE_W-1:0] b;
  logic [BYTE_W-1:0] b2;
  int                err_count;
  int                checked;
  int                i;

  // Clock at 40 MHz
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // Pin levels: whoever enables drives, else the host side
  assign pd_i = (pd_oe & pd_o) | (~pd_oe & host_d);
  assign cp_i = (cp_oe & cp_o) | (~cp_oe & strobe);

  psp_slave_port psp_slave_port_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pd_i(pd_i), .pd_o(pd_o), .pd_oe(pd_oe), .cp_i(cp_i),
    .cp_o(cp_o), .cp_oe(cp_oe), .slave_port_irq(slave_port_irq)
  );

  psp_host_model psp_host_model_inst (
    .pclk(pclk), .pd(pd_i), .strobe(strobe), .host_d(host_d)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Expected control/status value
  function automatic logic [7:0] csr(input logic input_full_flag, input logic output_full_flag, input logic input_overrun_flag,
                                     input logic mode);
    return {input_full_flag, output_full_flag, input_overrun_flag, mode, 4'h7};
  endfunction

  // Compare and count
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer, waiting for pready with no bound of its own
  task automatic apb(input logic wr_en, input logic [IDX_W-1:0] idx,
                     input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdv,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
    apb(1'b1, idx, {24'h0, v}, rd, err);
    chk({31'h0, err}, 32'h0, "write refused");
  endtask

  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [7:0] v, input string m);
    apb(1'b0, idx, 32'h0, rd, err);
    chk(rd, {24'h0, v}, m);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    conclude();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hac41));
    err_count = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and a refused address
    rdc(IDX_CSR, CSR_RESET, "csr reset");
    rdc(IDX_IRQ_FLAG, 8'h00, "irq flag reset");
    apb(1'b0, 8'h55, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "unmapped read");
    // Analog pins read zero, digital pins read the idle strobes
    rdc(IDX_CPIN_PORT, 8'h00, "analog pins");
    wr(IDX_ACFG, 8'h07);
    rdc(IDX_CPIN_PORT, 8'h07, "digital pins");
    // Control pins turned to outputs
    wr(IDX_CSR, 8'h00);
    wr(IDX_CPIN_PORT, 8'h05);
    rdc(IDX_CPIN_PORT, 8'h05, "pin readback");
    chk({29'h0, cp_oe}, 32'h7, "pin outputs");
    chk({29'h0, cp_o}, 32'h5, "pin latch");
    // Slave mode with the data direction set to outputs
    wr(IDX_DATA_DIR, 8'h00);
    wr(IDX_CSR, 8'h17);
    wr(IDX_IRQ_EN, 8'h80);
    rdc(IDX_CSR, csr(0, 0, 0, 1), "mode on");
    chk({24'h0, pd_oe}, 32'h0, "pins released");
    // Random host writes, short and long strobes
    for (i = 0; i < 6; i++) begin
      b = 8'($urandom);
      psp_host_model_inst.host_write(b, 1 + int'($urandom % 6));
      rdc(IDX_CSR, csr(1, 0, 0, 1), "full after write");
      rdc(IDX_IRQ_FLAG, 8'h80, "irq after write");
      chk({31'h0, slave_port_irq}, 32'h1, "irq out");
      rdc(IDX_DATA_PORT, b, "host byte");
      rdc(IDX_CSR, csr(0, 0, 0, 1), "cleared by read");
      wr(IDX_IRQ_FLAG, 8'h00);
      // Interrupt output follows the flag one cycle later
      repeat (2) @(posedge pclk);
      chk({31'h0, slave_port_irq}, 32'h0, "irq cleared");
    end
    // Second write onto an unread byte
    b = 8'($urandom);
    psp_host_model_inst.host_write(b, 3);
    psp_host_model_inst.host_write(~b, 2);
    rdc(IDX_CSR, csr(1, 0, 1, 1), "overrun");
    rdc(IDX_DATA_PORT, ~b, "latest byte");
    rdc(IDX_CSR, csr(0, 0, 1, 1), "overrun sticks");
    wr(IDX_CSR, 8'h17);
    rdc(IDX_CSR, csr(0, 0, 0, 1), "overrun cleared");
    // Host reads of the output latch
    for (i = 0; i < 4; i++) begin
      b = 8'($urandom);
      wr(IDX_DATA_PORT, b);
      rdc(IDX_CSR, csr(0, 1, 0, 1), "out full");
      wr(IDX_IRQ_FLAG, 8'h00);
      psp_host_model_inst.host_read(b2, 4 + int'($urandom % 3));
      chk({24'h0, b2}, {24'h0, b}, "host reads latch");
      chk({24'h0, pd_oe}, 32'h0, "pins released after read");
      rdc(IDX_CSR, csr(0, 0, 0, 1), "out emptied");
      rdc(IDX_IRQ_FLAG, 8'h80, "read complete");
    end
    // Masked interrupt still latches the flag
    wr(IDX_IRQ_EN, 8'h00);
    wr(IDX_IRQ_FLAG, 8'h00);
    psp_host_model_inst.host_write(8'h5a, 2);
    rdc(IDX_IRQ_FLAG, 8'h80, "flag while masked");
    chk({31'h0, slave_port_irq}, 32'h0, "masked irq");
    // Leaving slave mode clears full flags, keeps overrun
    psp_host_model_inst.host_write(8'ha5, 2);
    wr(IDX_DATA_PORT, 8'h3c);
    rdc(IDX_CSR, csr(1, 1, 1, 1), "flags before mode off");
    wr(IDX_CSR, 8'h27);
    rdc(IDX_CSR, csr(0, 0, 1, 0), "mode off");
    wr(IDX_CSR, 8'h07);
    rdc(IDX_CSR, CSR_RESET, "overrun cleared off");
    conclude();
  end
endmodule // psp_slave_port_tb
